// >>> hdl/dme_engine.sv
// DSP multiply-accumulate engine with APB control and status registers
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module dme_engine
    import dme_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Instruction and operands from the decoder
    input  wire logic        op_valid,
    input  wire dme_op_t     op_code,
    input  wire logic        acc_sel,
    input  wire dme_wb_t     wb_mode,
    input  wire logic [15:0] x_data,
    input  wire logic [15:0] y_data,
    input  wire logic        shift_use,
    input  wire logic [39:0] shift_data,
    input  wire logic [15:0] store_addr,
    input  wire logic [15:0] wb_ptr,
    input  wire logic        mul_word,
    input  wire logic        mul_x_signed,
    input  wire logic        mul_y_signed,
    // MCU multiply result
    output logic             mul_valid,
    output logic [31:0]      mul_result,
    // Write-back of the other accumulator to a working register
    output logic             wreg_write,
    output logic [15:0]      wreg_data,
    // Data space write over the X bus
    output logic             mem_write,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_data,
    // Pointer post-increment
    output logic             ptr_write,
    output logic [15:0]      ptr_data,
    // Status and trap
    output logic             acc_a_guard_overflow,
    output logic             acc_b_guard_overflow,
    output logic             acc_a_clamp_sticky,
    output logic             acc_b_clamp_sticky,
    output logic             either_guard_overflow,
    output logic             either_clamp_sticky,
    output logic             trap_request
);

    if (DATA_W != 16) begin : g_bad_width
        $error("dme_engine: DATA_W must be 16");
    end

    typedef struct packed {
        logic [39:0] acc_a;
        logic [39:0] acc_b;
        logic        ga;
        logic        gb;
        logic        sa;
        logic        sb;
        logic [15:0] core;
        logic [2:0]  trap;
        logic [31:0] rdata;
        logic        mul_vld;
        logic [31:0] mul_res;
        logic        wreg_wr;
        logic [15:0] wreg_d;
        logic        mem_wr;
        logic [15:0] mem_a;
        logic [15:0] mem_d;
        logic        ptr_wr;
        logic [15:0] ptr_d;
        logic        trap_req;
    } dme_state_t;

    dme_state_t s_reg;
    dme_state_t s_next;

    dme_rnd_if rif ();

    dme_round u_round (
        .rb (rif.rounder)
    );

    // Operand widening for the 17x17 multiplier
    function automatic logic signed [16:0] ext17(input logic [15:0] d,
                                                 input logic        uns);
        ext17 = uns ? {1'b0, d} : {d[15], d};
    endfunction

    // Mapped register test
    function automatic logic reg_hit(input logic [7:0] a);
        if (a == OFS_CORE) begin
            reg_hit = 1'b1;
        end else if (a == OFS_TRAP) begin
            reg_hit = 1'b1;
        end else if (a == OFS_STATUS) begin
            reg_hit = 1'b1;
        end else if (a == OFS_ACCA_LO || a == OFS_ACCA_HI) begin
            reg_hit = 1'b1;
        end else if (a == OFS_ACCB_LO || a == OFS_ACCB_HI) begin
            reg_hit = 1'b1;
        end else begin
            reg_hit = 1'b0;
        end
    endfunction

    // Read data multiplexer
    function automatic logic [31:0] reg_read(input logic [7:0] a,
                                             input dme_state_t s);
        if (a == OFS_CORE) begin
            reg_read = {16'h0, s.core};
        end else if (a == OFS_TRAP) begin
            reg_read = {29'h0, s.trap};
        end else if (a == OFS_STATUS) begin
            reg_read = {26'h0, s.sa | s.sb, s.ga | s.gb,
                        s.sb, s.sa, s.gb, s.ga};
        end else if (a == OFS_ACCA_LO) begin
            reg_read = s.acc_a[31:0];
        end else if (a == OFS_ACCA_HI) begin
            reg_read = {24'h0, s.acc_a[39:32]};
        end else if (a == OFS_ACCB_LO) begin
            reg_read = s.acc_b[31:0];
        end else if (a == OFS_ACCB_HI) begin
            reg_read = {24'h0, s.acc_b[39:32]};
        end else begin
            reg_read = 32'h0;
        end
    endfunction

    // Control bits
    logic        us_sel;
    logic        int_mode;
    logic        sat_a;
    logic        sat_b;
    logic        super_sel;
    assign us_sel    = s_reg.core[BIT_US];
    assign int_mode  = s_reg.core[BIT_IF];
    assign sat_a     = s_reg.core[BIT_ACC_A_CLAMP_ENABLE];
    assign sat_b     = s_reg.core[BIT_ACC_B_CLAMP_ENABLE];
    assign super_sel = s_reg.core[BIT_ACCSEL];

    // Instruction classes
    logic        is_ed;
    logic        is_mul;
    logic        is_load;
    logic        is_sac;
    logic        is_wbk;
    logic        is_add_op;
    logic        zero_src;
    logic        sub;
    assign is_ed     = op_code == OP_ED || op_code == OP_EUCLID_DISTANCE_ACCUM;
    assign is_mul    = op_code == OP_MUL;
    assign is_load   = op_code == OP_ADD || op_code == OP_LAC;
    assign is_sac    = op_code == OP_SAC || op_code == OP_SACR;
    assign is_wbk    = op_code == OP_MAC || op_code == OP_MSC ||
                       op_code == OP_CLR;
    assign is_add_op = op_code inside {OP_MAC, OP_MSC, OP_MPY, OP_MPYN,
                                       OP_ED, OP_EUCLID_DISTANCE_ACCUM, OP_ADD, OP_LAC,
                                       OP_CLR};
    assign zero_src  = op_code inside {OP_MPY, OP_MPYN, OP_ED, OP_LAC,
                                       OP_CLR};
    assign sub       = op_code == OP_MSC || op_code == OP_MPYN;

    // Multiplier and scaler
    logic [15:0]        diff;
    logic [15:0]        mx;
    logic [15:0]        my;
    logic               x_uns;
    logic               y_uns;
    logic signed [16:0] ex;
    logic signed [16:0] ey;
    logic signed [33:0] prod;
    logic [32:0]        p33;
    logic [32:0]        scaled;
    logic [39:0]        p40;
    assign diff   = x_data - y_data;
    assign mx     = is_ed ? diff :
                    (is_mul & ~mul_word) ? {8'h00, x_data[7:0]} : x_data;
    assign my     = is_ed ? diff :
                    (is_mul & ~mul_word) ? {8'h00, y_data[7:0]} : y_data;
    assign x_uns  = is_mul ? (~mul_x_signed | ~mul_word) : (us_sel & ~is_ed);
    assign y_uns  = is_mul ? (~mul_y_signed | ~mul_word) : (us_sel & ~is_ed);
    assign ex     = ext17(mx, x_uns);
    assign ey     = ext17(my, y_uns);
    assign prod   = ex * ey;
    assign p33    = prod[32:0];
    assign scaled = int_mode ? p33 : {p33[31:0], 1'b0};
    assign p40    = {{7{scaled[32]}}, scaled};

    // Accumulator adder/subtracter
    logic [39:0] tgt;
    logic [39:0] other;
    logic [39:0] src;
    logic [39:0] ld;
    logic [39:0] opnd;
    logic [39:0] bin;
    logic [39:0] sum;
    assign tgt   = acc_sel ? s_reg.acc_b : s_reg.acc_a;
    assign other = acc_sel ? s_reg.acc_a : s_reg.acc_b;
    assign src   = zero_src ? 40'h0 : tgt;
    assign ld    = shift_use ? shift_data
                             : {{8{x_data[15]}}, x_data, 16'h0};
    assign opnd  = is_load ? ld : (op_code == OP_CLR) ? 40'h0 : p40;
    assign bin   = sub ? ~opnd : opnd;
    assign sum   = src + bin + {39'h0, sub};

    // Overflow detection and saturation
    logic        sat_en;
    logic        ovf39;
    logic        ovf31;
    logic        sign_neg;
    logic        do_sat40;
    logic        do_sat32;
    logic [39:0] res;
    logic        sticky_set;
    logic        guard;
    assign sat_en     = acc_sel ? sat_b : sat_a;
    assign ovf39      = (src[39] == bin[39]) && (sum[39] != src[39]);
    assign ovf31      = ~((&sum[39:31]) | ~(|sum[39:31]));
    assign sign_neg   = ovf39 ? src[39] : sum[39];
    assign do_sat40   = sat_en & super_sel & ovf39;
    assign do_sat32   = sat_en & ~super_sel & (ovf39 | ovf31);
    assign res        = do_sat40 ? (sign_neg ? SAT40_NEG : SAT40_POS) :
                        do_sat32 ? (sign_neg ? SAT32_NEG : SAT32_POS) :
                        sum;
    assign sticky_set = do_sat40 | do_sat32 | (~sat_en & ovf39);
    assign guard      = ~(sat_en & ~super_sel) &
                        ~((&res[39:32]) | ~(|res[39:32]));

    // Round and write saturation inputs
    assign rif.acc      = is_sac ? tgt : other;
    assign rif.do_round = op_code != OP_SAC;
    assign rif.conv_sel = s_reg.core[BIT_RND];
    assign rif.clamp_en = s_reg.core[BIT_WRITE_CLAMP_ENABLE];

    // APB strobes
    logic apb_wr;
    logic clr_a;
    logic clr_b;
    assign apb_wr = psel & penable & pwrite;
    assign clr_a  = apb_wr && paddr == OFS_STATUS && pwdata[BIT_SA];
    assign clr_b  = apb_wr && paddr == OFS_STATUS && pwdata[BIT_SB];

    always_comb begin
        s_next         = s_reg;
        s_next.mul_vld = 1'b0;
        s_next.wreg_wr = 1'b0;
        s_next.mem_wr  = 1'b0;
        s_next.ptr_wr  = 1'b0;
        if (psel & ~penable) begin
            s_next.rdata = reg_read(paddr, s_reg);
        end
        if (apb_wr) begin
            if (paddr == OFS_CORE) begin
                s_next.core = pwdata[15:0] & CORE_MASK;
            end else if (paddr == OFS_TRAP) begin
                s_next.trap = pwdata[2:0];
            end
        end
        // Sticky flags: software clears, a same-cycle set wins
        s_next.sa = s_reg.sa & ~clr_a;
        s_next.sb = s_reg.sb & ~clr_b;
        if (op_valid & is_add_op) begin
            if (acc_sel) begin
                s_next.acc_b = res;
                s_next.gb    = guard;
                s_next.sb    = s_next.sb | sticky_set;
            end else begin
                s_next.acc_a = res;
                s_next.ga    = guard;
                s_next.sa    = s_next.sa | sticky_set;
            end
        end
        if (op_valid & is_wbk) begin
            if (wb_mode == WB_REG) begin
                s_next.wreg_wr = 1'b1;
                s_next.wreg_d  = rif.word;
            end else if (wb_mode == WB_MEM) begin
                s_next.mem_wr  = 1'b1;
                s_next.mem_a   = wb_ptr;
                s_next.mem_d   = rif.word;
                s_next.ptr_wr  = 1'b1;
                s_next.ptr_d   = wb_ptr + PTR_STEP;
            end
        end
        if (op_valid & is_sac) begin
            s_next.mem_wr = 1'b1;
            s_next.mem_a  = store_addr;
            s_next.mem_d  = rif.word;
        end
        if (op_valid & is_mul) begin
            s_next.mul_vld = 1'b1;
            s_next.mul_res = mul_word ? prod[31:0]
                                      : {16'h0, prod[15:0]};
        end
        // Trap request from the flags as they will stand after this cycle
        s_next.trap_req =
            (s_next.ga & s_reg.trap[BIT_ACC_A_OVERFLOW_TRAP_ENABLE]) |
            (s_next.gb & s_reg.trap[BIT_ACC_B_OVERFLOW_TRAP_ENABLE]) |
            (s_reg.trap[BIT_CATASTROPHIC_TRAP_ENABLE] &
             ((s_next.sa & ~sat_a) | (s_next.sb & ~sat_b)));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{core: CORE_RST, trap: TRAP_RST, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // APB answers without wait states
    assign pready  = 1'b1;
    assign prdata  = s_reg.rdata;
    assign pslverr = psel & penable & ~reg_hit(paddr);

    // Outputs
    assign mul_valid             = s_reg.mul_vld;
    assign mul_result            = s_reg.mul_res;
    assign wreg_write            = s_reg.wreg_wr;
    assign wreg_data             = s_reg.wreg_d;
    assign mem_write             = s_reg.mem_wr;
    assign mem_addr              = s_reg.mem_a;
    assign mem_data              = s_reg.mem_d;
    assign ptr_write             = s_reg.ptr_wr;
    assign ptr_data              = s_reg.ptr_d;
    assign acc_a_guard_overflow  = s_reg.ga;
    assign acc_b_guard_overflow  = s_reg.gb;
    assign acc_a_clamp_sticky    = s_reg.sa;
    assign acc_b_clamp_sticky    = s_reg.sb;
    assign either_guard_overflow = s_reg.ga | s_reg.gb;
    assign either_clamp_sticky   = s_reg.sa | s_reg.sb;
    assign trap_request          = s_reg.trap_req;

endmodule

// >>> hdl/dme_pkg.sv
// Constants and types shared by the DSP multiply-accumulate engine
package dme_pkg;

    // APB register offsets (byte addresses)
    localparam logic [7:0]  OFS_CORE       = 8'h00;
    localparam logic [7:0]  OFS_TRAP       = 8'h04;
    localparam logic [7:0]  OFS_STATUS     = 8'h08;
    localparam logic [7:0]  OFS_ACCA_LO    = 8'h0c;
    localparam logic [7:0]  OFS_ACCA_HI    = 8'h10;
    localparam logic [7:0]  OFS_ACCB_LO    = 8'h14;
    localparam logic [7:0]  OFS_ACCB_HI    = 8'h18;

    // core_control_reg field positions
    localparam int          BIT_IF         = 0;
    localparam int          BIT_RND        = 1;
    localparam int          BIT_ACCSEL     = 4;
    localparam int          BIT_WRITE_CLAMP_ENABLE      = 5;
    localparam int          BIT_ACC_B_CLAMP_ENABLE       = 6;
    localparam int          BIT_ACC_A_CLAMP_ENABLE       = 7;
    localparam int          BIT_US         = 12;

    // trap_control_reg field positions
    localparam int          BIT_ACC_A_OVERFLOW_TRAP_ENABLE      = 0;
    localparam int          BIT_ACC_B_OVERFLOW_TRAP_ENABLE      = 1;
    localparam int          BIT_CATASTROPHIC_TRAP_ENABLE      = 2;

    // Status register field positions
    localparam int          BIT_GA         = 0;
    localparam int          BIT_GB         = 1;
    localparam int          BIT_SA         = 2;
    localparam int          BIT_SB         = 3;
    localparam int          BIT_GAB        = 4;
    localparam int          BIT_SAB        = 5;

    // Reset values and write masks
    localparam logic [15:0] CORE_RST       = 16'h0020;
    localparam logic [15:0] CORE_MASK      = 16'h10f3;
    localparam logic [2:0]  TRAP_RST       = 3'h0;

    // Saturation, rounding and pointer step constants
    localparam logic [39:0] SAT40_POS      = 40'h7fffffffff;
    localparam logic [39:0] SAT40_NEG      = 40'h8000000000;
    localparam logic [39:0] SAT32_POS      = 40'h007fffffff;
    localparam logic [39:0] SAT32_NEG      = 40'h0080000000;
    localparam logic [15:0] ROUND_HALF     = 16'h8000;
    localparam logic [15:0] WR_POS         = 16'h7fff;
    localparam logic [15:0] WR_NEG         = 16'h8000;
    localparam logic [15:0] PTR_STEP       = 16'h0002;

    // Instruction codes presented by the decoder
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_MAC  = 4'h1,
        OP_MSC  = 4'h2,
        OP_MPY  = 4'h3,
        OP_MPYN = 4'h4,
        OP_ED   = 4'h5,
        OP_EUCLID_DISTANCE_ACCUM = 4'h6,
        OP_ADD  = 4'h7,
        OP_LAC  = 4'h8,
        OP_CLR  = 4'h9,
        OP_SAC  = 4'ha,
        OP_SACR = 4'hb,
        OP_MUL  = 4'hc
    } dme_op_t;

    // Write-back destinations
    typedef enum logic [1:0] {
        WB_NONE = 2'h0,
        WB_REG  = 2'h1,
        WB_MEM  = 2'h2
    } dme_wb_t;

endpackage

// >>> hdl/dme_rnd_if.sv
// Signals between the engine and its round and write-saturation logic
`timescale 1ns/1ps
interface dme_rnd_if;
    logic [39:0] acc;
    logic        do_round;
    logic        conv_sel;
    logic        clamp_en;
    logic [15:0] word;

    modport user    (output acc, output do_round, output conv_sel,
                     output clamp_en, input word);
    modport rounder (input acc, input do_round, input conv_sel,
                     input clamp_en, output word);
endinterface

// >>> hdl/dme_round.sv
// Round logic and data write saturation for accumulator stores
`timescale 1ns/1ps
module dme_round
    import dme_pkg::*;
(
    // Accumulator in, 1.15 word out
    dme_rnd_if.rounder rb
);
    logic [15:0] lo;
    logic        half;
    logic        inc;
    logic [24:0] full;
    logic        pos_ovf;
    logic        neg_ovf;

    assign lo      = rb.acc[15:0];
    assign half    = lo == ROUND_HALF;
    // Conventional on upper half, convergent ties on bit 16
    assign inc     = rb.do_round & lo[15] &
                     (rb.conv_sel | ~half | rb.acc[16]);
    assign full    = {rb.acc[39], rb.acc[39:16]} + {24'h0, inc};
    // Sign taken from bit 39 of the source
    assign pos_ovf = ~rb.acc[39] & (|full[24:15]);
    assign neg_ovf = rb.acc[39] & full[24] & ~(&full[23:15]);
    assign rb.word = (rb.clamp_en & pos_ovf) ? WR_POS :
                     (rb.clamp_en & neg_ovf) ? WR_NEG :
                     full[15:0];
endmodule

// >>> sim/dme_engine_properties.sv
// Port-level assertions for the multiply-accumulate engine
`timescale 1ns/1ps
module dme_engine_properties
    import dme_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    // Instruction
    input wire logic        op_valid,
    input wire dme_op_t     op_code,
    input wire logic [15:0] wb_ptr,
    input wire logic        mul_word,
    // Results
    input wire logic        mul_valid,
    input wire logic [31:0] mul_result,
    input wire logic        mem_write,
    input wire logic [15:0] mem_addr,
    input wire logic        ptr_write,
    input wire logic [15:0] ptr_data,
    // Flags and trap
    input wire logic        acc_a_guard_overflow,
    input wire logic        acc_b_guard_overflow,
    input wire logic        acc_a_clamp_sticky,
    input wire logic        acc_b_clamp_sticky,
    input wire logic        either_guard_overflow,
    input wire logic        either_clamp_sticky,
    input wire logic        trap_request
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_either_guard: assert property (
        either_guard_overflow == (acc_a_guard_overflow | acc_b_guard_overflow))
        else $error("combined guard flag differs from its parts");
    chk_either_sticky: assert property (
        either_clamp_sticky == (acc_a_clamp_sticky | acc_b_clamp_sticky))
        else $error("combined sticky flag differs from its parts");
    chk_sticky_a_hold: assert property (
        $fell(acc_a_clamp_sticky) |->
        $past(psel && penable && pwrite && paddr == OFS_STATUS))
        else $error("sticky A cleared without a status write");
    chk_sticky_b_hold: assert property (
        $fell(acc_b_clamp_sticky) |->
        $past(psel && penable && pwrite && paddr == OFS_STATUS))
        else $error("sticky B cleared without a status write");
    chk_sticky_set_time: assert property (
        $rose(acc_a_clamp_sticky) |-> $past(op_valid))
        else $error("sticky A set without an operation");
    chk_guard_update: assert property (
        $changed(acc_b_guard_overflow) |-> $past(op_valid))
        else $error("guard B changed without an operation");
    chk_mul_pulse: assert property (
        mul_valid |-> $past(op_valid && op_code == OP_MUL))
        else $error("product pulse without a multiply");
    chk_mul_byte: assert property (
        mul_valid && !$past(mul_word) |-> mul_result[31:16] == 16'h0000)
        else $error("byte product wider than 16 bits");
    chk_ptr_step: assert property (
        ptr_write |-> mem_write && mem_addr == $past(wb_ptr) &&
        ptr_data == $past(wb_ptr) + PTR_STEP)
        else $error("pointer write-back address or step wrong");
    chk_trap_cause: assert property (
        !(acc_a_guard_overflow || acc_b_guard_overflow ||
          acc_a_clamp_sticky || acc_b_clamp_sticky) |-> !trap_request)
        else $error("trap request with no flag set");

    cover property ($rose(acc_a_clamp_sticky));
    cover property (ptr_write);
    cover property (mul_valid && mul_word);
    cover property (trap_request);
endmodule

bind dme_engine dme_engine_properties #(.DATA_W(DATA_W))
    dme_engine_properties_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .op_valid, .op_code,
    .wb_ptr, .mul_word, .mul_valid, .mul_result, .mem_write, .mem_addr,
    .ptr_write, .ptr_data, .acc_a_guard_overflow, .acc_b_guard_overflow,
    .acc_a_clamp_sticky, .acc_b_clamp_sticky, .either_guard_overflow,
    .either_clamp_sticky, .trap_request);

// >>> sim/dme_engine_test.sv
// Self-checking bench for the multiply-accumulate engine
`timescale 1ns/1ps
module dme_engine_test;
    import dme_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        op_valid, acc_sel, shift_use, mul_word, mul_x_signed;
    logic        mul_y_signed, mul_valid, wreg_write, mem_write, ptr_write;
    logic        acc_a_guard_overflow, acc_b_guard_overflow, trap_request;
    logic        acc_a_clamp_sticky, acc_b_clamp_sticky, sv;
    logic        either_guard_overflow, either_clamp_sticky;
    logic [2:0]  tv, fv, m3;
    logic [3:0]  oc;
    logic [7:0]  paddr;
    logic [15:0] x_data, y_data, store_addr, wb_ptr, wreg_data, mem_addr;
    logic [15:0] mem_data, ptr_data, cv, xv, yv, rv;
    logic [31:0] pwdata, prdata, mul_result, q, pv;
    logic [39:0] shift_data, v, lv, av, ev;
    dme_op_t     op_code;
    dme_wb_t     wb_mode;
    int          mismatches, checked;
    logic [87:0]  mt [5] = '{{16'h0020, 16'h4000, 16'h4000, 40'h0020000000},
        {16'h0021, 16'h4000, 16'h4000, 40'h0010000000},
        {16'h0021, 16'hffff, 16'h0002, 40'hfffffffffe},
        {16'h1021, 16'hffff, 16'h0002, 40'h000001fffe},
        {16'h0020, 16'h8000, 16'h8000, 40'h0080000000}};
    logic [66:0]  ut [4] = '{{3'h0, 16'h00ff, 16'h00ff, 32'h0000fe01},
        {3'h4, 16'hffff, 16'h0002, 32'h0001fffe},
        {3'h7, 16'hffff, 16'h0002, 32'hfffffffe},
        {3'h6, 16'hffff, 16'hffff, 32'hffff0001}};
    logic [142:0] st [6] = '{
        {16'h00b0, 3'h0, 1'b0, 40'h7fffffffff, 40'h1, 40'h7fffffffff, 3'h6},
        {16'h00a0, 3'h0, 1'b0, 40'h007fffffff, 40'h1, 40'h007fffffff, 3'h2},
        {16'h00a0, 3'h0, 1'b0, 40'hff80000000, 40'hffffffffff,
         40'h0080000000, 3'h2},
        {16'h0020, 3'h4, 1'b0, 40'h7fffffffff, 40'h1, 40'h8000000000, 3'h7},
        {16'h0020, 3'h2, 1'b1, 40'h0, 40'h0100000000, 40'h0100000000, 3'h5},
        {16'h0060, 3'h0, 1'b0, 40'h007fffffff, 40'h1, 40'h0080000000, 3'h0}};
    logic [75:0]  rt [9] = '{{OP_SACR, 16'h0022, 40'h0012348000, 16'h1235},
        {OP_SACR, 16'h0020, 40'h0012348000, 16'h1234},
        {OP_SACR, 16'h0020, 40'h0012358000, 16'h1236},
        {OP_SACR, 16'h0022, 40'h0012347fff, 16'h1234},
        {OP_SACR, 16'h0020, 40'h001234ffff, 16'h1235},
        {OP_SAC, 16'h0022, 40'h001234ffff, 16'h1234},
        {OP_SAC, 16'h0020, 40'h0100000000, 16'h7fff},
        {OP_SAC, 16'h0000, 40'h0100000000, 16'h0000},
        {OP_SAC, 16'h0020, 40'hff00000000, 16'h8000}};

    dme_engine #(.DATA_W(16)) dme_engine_inst (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
        .prdata, .pslverr, .op_valid, .op_code, .acc_sel, .wb_mode, .x_data,
        .y_data, .shift_use, .shift_data, .store_addr, .wb_ptr, .mul_word,
        .mul_x_signed, .mul_y_signed, .mul_valid, .mul_result, .wreg_write,
        .wreg_data, .mem_write, .mem_addr, .mem_data, .ptr_write, .ptr_data,
        .acc_a_guard_overflow, .acc_b_guard_overflow, .acc_a_clamp_sticky,
        .acc_b_clamp_sticky, .either_guard_overflow, .either_clamp_sticky,
        .trap_request);

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic rd_acc(input logic s);
        apb(1'b0, s ? OFS_ACCB_LO : OFS_ACCA_LO, 32'h0);
        v[31:0] = q;
        apb(1'b0, s ? OFS_ACCB_HI : OFS_ACCA_HI, 32'h0);
        v[39:32] = q[7:0];
    endtask

    task automatic op(input logic [3:0] c, input logic s,
                      input logic [15:0] x, input logic [15:0] y,
                      input logic [39:0] sh, input dme_wb_t wb,
                      input logic [2:0] m);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_code <= dme_op_t'(c);
        acc_sel <= s;
        x_data <= x;
        y_data <= y;
        shift_data <= sh;
        wb_mode <= wb;
        {mul_word, mul_x_signed, mul_y_signed} <= m;
        @(posedge pclk);
        op_valid <= 1'b0;
        #1;
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        #100000;
        mismatches++;
        end_sim();
    end

    initial begin
        {presetn, psel, penable, pwrite, op_valid, acc_sel} = '0;
        {mul_word, mul_x_signed, mul_y_signed} = '0;
        {paddr, pwdata, x_data, y_data, shift_data} = '0;
        op_code = OP_NONE;
        wb_mode = WB_NONE;
        shift_use = 1'b1;
        store_addr = 16'h0800;
        wb_ptr = 16'h1000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CORE, 32'h0);
        chk(q, {16'h0, CORE_RST});
        apb(1'b0, 8'h1c, 32'h0);
        chk({e, q}, {1'b1, 32'h0});
        apb(1'b1, OFS_ACCA_LO, 32'hffffffff);
        rd_acc(1'b0);
        chk(v, 40'h0);
        for (int i = 0; i < 5; i++) begin
            {cv, xv, yv, ev} = mt[i];
            apb(1'b1, OFS_CORE, {16'h0, cv});
            op(OP_MPY, 1'b0, xv, yv, 40'h0, WB_NONE, 3'h0);
            rd_acc(1'b0);
            chk(v, ev);
        end
        for (int i = 0; i < 4; i++) begin
            {m3, xv, yv, pv} = ut[i];
            op(OP_MUL, 1'b0, xv, yv, 40'h0, WB_NONE, m3);
            chk({mul_valid, mul_result}, {1'b1, pv});
        end
        for (int i = 0; i < 6; i++) begin
            {cv, tv, sv, lv, av, ev, fv} = st[i];
            apb(1'b1, OFS_CORE, {16'h0, cv});
            apb(1'b1, OFS_TRAP, {29'h0, tv});
            apb(1'b1, OFS_STATUS, 32'hc);
            op(OP_LAC, sv, 16'h0, 16'h0, lv, WB_NONE, 3'h0);
            op(OP_ADD, sv, 16'h0, 16'h0, av, WB_NONE, 3'h0);
            chk(sv ? {acc_b_guard_overflow, acc_b_clamp_sticky, trap_request}
                : {acc_a_guard_overflow, acc_a_clamp_sticky, trap_request},
                fv);
            rd_acc(sv);
            chk(v, ev);
        end
        op(OP_ADD, 1'b1, 16'h0, 16'h0, 40'h0, WB_NONE, 3'h0);
        chk(acc_b_clamp_sticky, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h8);
        chk(acc_b_clamp_sticky, 1'b0);
        for (int i = 0; i < 9; i++) begin
            {oc, cv, lv, rv} = rt[i];
            apb(1'b1, OFS_CORE, {16'h0, cv});
            op(OP_LAC, 1'b0, 16'h0, 16'h0, lv, WB_NONE, 3'h0);
            op(oc, 1'b0, 16'h0, 16'h0, 40'h0, WB_NONE, 3'h0);
            chk({mem_write, mem_addr, mem_data}, {1'b1, store_addr, rv});
        end
        apb(1'b1, OFS_CORE, 32'h23);
        op(OP_LAC, 1'b1, 16'h0, 16'h0, 40'h0012348000, WB_NONE, 3'h0);
        op(OP_LAC, 1'b0, 16'h0, 16'h0, 40'h0000001000, WB_NONE, 3'h0);
        op(OP_MAC, 1'b0, 16'h0, 16'h0, 40'h0, WB_REG, 3'h0);
        chk({wreg_write, wreg_data}, {1'b1, 16'h1235});
        op(OP_MSC, 1'b0, 16'h2, 16'h3, 40'h0, WB_MEM, 3'h0);
        chk({mem_write, mem_addr, mem_data}, {1'b1, wb_ptr, 16'h1235});
        chk({ptr_write, ptr_data}, {1'b1, wb_ptr + PTR_STEP});
        rd_acc(1'b0);
        chk(v, 40'h0000000ffa);
        op(OP_MPY, 1'b0, 16'h0, 16'h0, 40'h0, WB_MEM, 3'h0);
        chk({mem_write, ptr_write}, 2'b00);
        shift_use <= 1'b0;
        op(OP_LAC, 1'b0, 16'h8000, 16'h0, 40'h0, WB_NONE, 3'h0);
        op(OP_EUCLID_DISTANCE_ACCUM, 1'b0, 16'h5, 16'h2, 40'h0, WB_NONE, 3'h0);
        rd_acc(1'b0);
        chk(v, 40'hff80000009);
        op(OP_MPYN, 1'b1, 16'h3, 16'h2, 40'h0, WB_NONE, 3'h0);
        rd_acc(1'b1);
        chk(v, 40'hfffffffffa);
        end_sim();
    end
endmodule
